// ===== bench/chglim_host_model.sv
`timescale 1ns/10ps
// Host side: register access strobes and the register-reset control
module chglim_host_model import chglim_pkg::*; (
    input wire logic sys_clk,
    input wire logic [15:0] readData,
    input wire logic readValid,
    output chglim_access_s hostAccess,
    output logic registerResetRequest
);
    initial begin
        hostAccess = '0;
        registerResetRequest = 1'b0;
    end

    // One write held over one sampling edge, bus scrambled once released
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(negedge sys_clk);
        hostAccess = '{write: 1'b1, read: 1'b0, addr: a, data: d};
        @(negedge sys_clk);
        hostAccess = '{write: 1'b0, read: 1'b0, addr: ~a, data: ~d};
    endtask : wr

    // One read, answer pulse awaited for a bounded number of cycles
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        int n = 0;
        @(negedge sys_clk);
        hostAccess = '{write: 1'b0, read: 1'b1, addr: a, data: 16'h5a5a};
        @(negedge sys_clk);
        hostAccess = '{write: 1'b0, read: 1'b0, addr: ~a, data: 16'ha5a5};
        while (readValid !== 1'b1 && n < 4) begin
            @(negedge sys_clk);
            n++;
        end
        d = (readValid === 1'b1) ? readData : 16'hxxxx;
    endtask : rd

    // Single-cycle register-reset request
    task automatic regrst();
        @(negedge sys_clk);
        registerResetRequest = 1'b1;
        @(negedge sys_clk);
        registerResetRequest = 1'b0;
    endtask : regrst
endmodule : chglim_host_model

// ===== bench/tb_top.sv
`timescale 1ns/10ps
module tb_top import chglim_pkg::*;;
    logic sys_clk, rst, readValid, watchdogExpire, registerResetRequest, timerRestart, adapterPresent;
    logic [15:0] readData;
    logic [1:0] cellCountStrapPin;
    logic [7:0] inputBusVoltage;
    chglim_access_s hostAccess;
    chglim_limits_s limits;
    int failures = 0;
    int compares = 0;
    int cycles = 0;

    chglim_registers u_dut (.sys_clk(sys_clk), .rst(rst), .hostAccess(hostAccess), .readData(readData),
        .readValid(readValid), .cellCountStrapPin(cellCountStrapPin), .watchdogExpire(watchdogExpire),
        .registerResetRequest(registerResetRequest), .timerRestart(timerRestart),
        .adapterPresent(adapterPresent), .inputBusVoltage(inputBusVoltage), .limits(limits));
    chglim_host_model u_host (.sys_clk(sys_clk), .readData(readData), .readValid(readValid),
        .hostAccess(hostAccess), .registerResetRequest(registerResetRequest));

    initial begin
        sys_clk = 1'b0;
    end
    always #50 sys_clk = ~sys_clk;

    // Verdict and end of run
    task automatic end_sim();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_sim

    // Hang guard
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 2000) begin
            failures++;
            end_sim();
        end
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // Read a register and compare
    task automatic rc(input logic [7:0] a, input logic [15:0] exp);
        logic [15:0] d;
        u_host.rd(a, d);
        chk(d, exp);
    endtask : rc

    // Mid-run reset with another strap, then the power-on defaults
    task automatic por(input logic [1:0] cells, input logic [15:0] f, input logic [15:0] v, input logic [15:0] i);
        @(negedge sys_clk);
        rst = 1'b1;
        adapterPresent = 1'b0;
        cellCountStrapPin = cells;
        repeat (16) @(negedge sys_clk);
        rst = 1'b0;
        repeat (3) @(negedge sys_clk);
        rc(ADDR_SYS_FLOOR, f);
        rc(ADDR_BAT_BATTERY_REGULATION_VOLTAGE, v);
        rc(ADDR_BAT_ILIM, i);
        rc(ADDR_IN_VTH, 16'h0024);
    endtask : por

    initial begin
        rst = 1'b1;
        cellCountStrapPin = CELLS_3;
        watchdogExpire = 1'b0;
        adapterPresent = 1'b0;
        inputBusVoltage = 8'h00;
        repeat (16) @(negedge sys_clk);
        rst = 1'b0;
        repeat (3) @(negedge sys_clk);
        // Three-cell power-on defaults
        rc(ADDR_SYS_FLOOR, 16'h001a);
        rc(ADDR_BAT_BATTERY_REGULATION_VOLTAGE, 16'h04ec);
        rc(ADDR_BAT_ILIM, 16'h0064);
        rc(ADDR_IN_VTH, 16'h0024);
        $display("test defaults done");
        // Clamp edges, reserved bits and an unmapped offset
        u_host.wr(ADDR_SYS_FLOOR, 16'h0037);
        rc(ADDR_SYS_FLOOR, 16'h001a);
        u_host.wr(ADDR_SYS_FLOOR, 16'h0036);
        rc(ADDR_SYS_FLOOR, 16'h0036);
        u_host.wr(ADDR_BAT_BATTERY_REGULATION_VOLTAGE, 16'h012b);
        rc(ADDR_BAT_BATTERY_REGULATION_VOLTAGE, 16'h04ec);
        u_host.wr(ADDR_BAT_BATTERY_REGULATION_VOLTAGE, 16'hf92c);
        rc(ADDR_BAT_BATTERY_REGULATION_VOLTAGE, 16'h012c);
        u_host.wr(ADDR_BAT_ILIM, 16'h0004);
        rc(ADDR_BAT_ILIM, 16'h0064);
        u_host.wr(ADDR_BAT_ILIM, 16'hfe05);
        rc(ADDR_BAT_ILIM, 16'h0005);
        u_host.wr(ADDR_IN_VTH, 16'h0023);
        rc(ADDR_IN_VTH, 16'h0024);
        u_host.wr(ADDR_IN_VTH, 16'h00dc);
        rc(ADDR_IN_VTH, 16'h00dc);
        u_host.wr(8'h02, 16'h1234);
        rc(8'h02, 16'h0000);
        $display("test clamps done");
        // Watchdog reloads only the current limit
        @(negedge sys_clk);
        watchdogExpire = 1'b1;
        @(negedge sys_clk);
        watchdogExpire = 1'b0;
        chk({7'h00, limits.batteryCurrentLimit}, 16'h0064);
        chk({5'h00, limits.batteryRegulationVoltage}, 16'h012c);
        chk({10'h000, limits.systemVoltageFloor}, 16'h0036);
        chk({8'h00, limits.inputVoltageThreshold}, 16'h00dc);
        $display("test watchdog done");
        // Register reset with the strap moved after power-on
        u_host.wr(ADDR_BAT_ILIM, 16'h0005);
        cellCountStrapPin = CELLS_1;
        u_host.regrst();
        chk({15'h0000, timerRestart}, 16'h0001);
        chk({10'h000, limits.systemVoltageFloor}, 16'h001a);
        chk({5'h00, limits.batteryRegulationVoltage}, 16'h04ec);
        chk({7'h00, limits.batteryCurrentLimit}, 16'h0064);
        chk({8'h00, limits.inputVoltageThreshold}, 16'h00dc);
        @(negedge sys_clk);
        chk({15'h0000, timerRestart}, 16'h0000);
        $display("test register reset done");
        // Adapter attach and removal
        inputBusVoltage = 8'h32;
        adapterPresent = 1'b1;
        repeat (2) @(negedge sys_clk);
        chk({8'h00, limits.inputVoltageThreshold}, 16'h0032);
        adapterPresent = 1'b0;
        repeat (2) @(negedge sys_clk);
        rc(ADDR_IN_VTH, 16'h0024);
        inputBusVoltage = 8'h10;
        adapterPresent = 1'b1;
        repeat (2) @(negedge sys_clk);
        chk({8'h00, limits.inputVoltageThreshold}, 16'h0024);
        $display("test adapter done");
        // Other strapped cell counts
        por(CELLS_1, 16'h0004, 16'h01a4, 16'h00c8);
        por(CELLS_2, 16'h0012, 16'h0348, 16'h00c8);
        por(CELLS_4, 16'h0026, 16'h0690, 16'h0064);
        $display("test power-on straps done");
        end_sim();
    end
endmodule : tb_top

// ===== rtl/chglim_pkg.sv
package chglim_pkg;

    // Register offsets
    localparam logic [7:0] ADDR_SYS_FLOOR = 8'h00;
    localparam logic [7:0] ADDR_BAT_BATTERY_REGULATION_VOLTAGE = 8'h01;
    localparam logic [7:0] ADDR_BAT_ILIM = 8'h03;
    localparam logic [7:0] ADDR_IN_VTH = 8'h05;

    // Field widths
    localparam int SYS_FLOOR_W = 6;
    localparam int BAT_BATTERY_REGULATION_VOLTAGE_W = 11;
    localparam int BAT_ILIM_W = 9;
    localparam int IN_VTH_W = 8;

    // Field codes: floor is 2500mV + 250mV/code, others zero offset
    localparam logic [5:0] SYS_FLOOR_MAX = 6'h36;      // 16000mV
    localparam logic [5:0] SYS_FLOOR_DEF_1S = 6'h04;   // 3.5V
    localparam logic [5:0] SYS_FLOOR_DEF_2S = 6'h12;   // 7V
    localparam logic [5:0] SYS_FLOOR_DEF_3S = 6'h1a;   // 9V
    localparam logic [5:0] SYS_FLOOR_DEF_4S = 6'h26;   // 12V
    localparam logic [10:0] BAT_BATTERY_REGULATION_VOLTAGE_MIN = 11'h12c;    // 3000mV at 10mV/code
    localparam logic [10:0] BAT_BATTERY_REGULATION_VOLTAGE_MAX = 11'h758;    // 18800mV
    localparam logic [10:0] BAT_BATTERY_REGULATION_VOLTAGE_DEF_1S = 11'h1a4; // 4.2V
    localparam logic [10:0] BAT_BATTERY_REGULATION_VOLTAGE_DEF_2S = 11'h348; // 8.4V
    localparam logic [10:0] BAT_BATTERY_REGULATION_VOLTAGE_DEF_3S = 11'h4ec; // 12.6V
    localparam logic [10:0] BAT_BATTERY_REGULATION_VOLTAGE_DEF_4S = 11'h690; // 16.8V
    localparam logic [8:0] BAT_ILIM_MIN = 9'h005;      // 50mA at 10mA/code
    localparam logic [8:0] BAT_ILIM_MAX = 9'h12c;      // 3000mA
    localparam logic [8:0] BAT_ILIM_DEF_LO = 9'h0c8;   // 2A for one or two cells
    localparam logic [8:0] BAT_ILIM_DEF_HI = 9'h064;   // 1A for three or four cells
    localparam logic [7:0] IN_VTH_MIN = 8'h24;         // 3600mV at 100mV/code
    localparam logic [7:0] IN_VTH_MAX = 8'hdc;         // 22000mV
    localparam logic [7:0] IN_VTH_RESET = 8'h24;

    // Strap cell count encoding
    localparam logic [1:0] CELLS_1 = 2'h0;
    localparam logic [1:0] CELLS_2 = 2'h1;
    localparam logic [1:0] CELLS_3 = 2'h2;
    localparam logic [1:0] CELLS_4 = 2'h3;

    // Live limit values handed to the regulation logic
    typedef struct packed {
        logic [5:0] systemVoltageFloor;
        logic [10:0] batteryRegulationVoltage;
        logic [8:0] batteryCurrentLimit;
        logic [7:0] inputVoltageThreshold;
    } chglim_limits_s;

    // Host register access strobe group
    typedef struct packed {
        logic write;
        logic read;
        logic [7:0] addr;
        logic [15:0] data;
    } chglim_access_s;

endpackage : chglim_pkg

// ===== rtl/chglim_registers.sv
`timescale 1ns/10ps
// Operation
// - Floor: six bits, 2500mV plus 250mV/code
// - Floor default from strapped cell count
// - Charge voltage: eleven bits, 10mV per code
// - Charge voltage default from strapped cell count
// - Charge current: nine bits, 10mA per code
// - Current default 2A low cells, 1A high
// - Current reloads on watchdog and register reset
// - Floor and charge voltage reload only on strap load and register reset
// - Input threshold: eight bits, 100mV, reset 24h
// - Adapter removal forces threshold to 3600mV
// - Adapter attach loads threshold from measurement
// - Threshold survives register reset and watchdog
// - Ignore writes below minimum on clamped-low fields
// - Ignore floor writes above maximum
// - Register reset restores defaults, restarts timer
module chglim_registers import chglim_pkg::*; (
    input wire logic sys_clk,
    input wire logic rst,
    input wire chglim_access_s hostAccess,
    output logic [15:0] readData,
    output logic readValid,
    input wire logic [1:0] cellCountStrapPin,
    input wire logic watchdogExpire,
    input wire logic registerResetRequest,
    output logic timerRestart,
    input wire logic adapterPresent,
    input wire logic [7:0] inputBusVoltage,
    output chglim_limits_s limits
);

    logic [5:0] floor_reg;
    logic [10:0] battery_regulation_voltage_reg;
    logic [8:0] ilim_reg;
    logic [7:0] vth_reg;
    logic [1:0] cells_reg;
    logic strapTaken_reg;
    logic strapLoad_reg;
    logic adapter_reg;
    logic [5:0] floorDefault;
    logic [10:0] vregDefault;
    logic [8:0] ilimDefault;
    logic [7:0] vthFromBus;
    logic wrFloor;
    logic wrVreg;
    logic wrIlim;
    logic wrVth;
    logic loadDefaults;

    // Write decode with clamping
    assign wrFloor = hostAccess.write && hostAccess.addr == ADDR_SYS_FLOOR
        && hostAccess.data[5:0] <= SYS_FLOOR_MAX;
    assign wrVreg = hostAccess.write && hostAccess.addr == ADDR_BAT_BATTERY_REGULATION_VOLTAGE
        && hostAccess.data[10:0] >= BAT_BATTERY_REGULATION_VOLTAGE_MIN;
    assign wrIlim = hostAccess.write && hostAccess.addr == ADDR_BAT_ILIM
        && hostAccess.data[8:0] >= BAT_ILIM_MIN;
    assign wrVth = hostAccess.write && hostAccess.addr == ADDR_IN_VTH
        && hostAccess.data[7:0] >= IN_VTH_MIN;

    // Default tables indexed by cell count
    always_comb begin
        unique case (cells_reg)
            CELLS_1: begin
                floorDefault = SYS_FLOOR_DEF_1S;
                vregDefault = BAT_BATTERY_REGULATION_VOLTAGE_DEF_1S;
            end
            CELLS_2: begin
                floorDefault = SYS_FLOOR_DEF_2S;
                vregDefault = BAT_BATTERY_REGULATION_VOLTAGE_DEF_2S;
            end
            CELLS_3: begin
                floorDefault = SYS_FLOOR_DEF_3S;
                vregDefault = BAT_BATTERY_REGULATION_VOLTAGE_DEF_3S;
            end
            CELLS_4: begin
                floorDefault = SYS_FLOOR_DEF_4S;
                vregDefault = BAT_BATTERY_REGULATION_VOLTAGE_DEF_4S;
            end
        endcase
        ilimDefault = (cells_reg == CELLS_1 || cells_reg == CELLS_2) ? BAT_ILIM_DEF_LO : BAT_ILIM_DEF_HI;
    end

    // Measured bus code raised to the threshold floor
    assign vthFromBus = (inputBusVoltage < IN_VTH_MIN) ? IN_VTH_MIN : inputBusVoltage;

    // Second edge after reset release loads strap-based defaults, as does a register reset
    assign loadDefaults = strapLoad_reg || registerResetRequest;

    // Strap capture, once after reset release
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            strapTaken_reg <= 1'b0;
            cells_reg <= CELLS_1;
        end else if (!strapTaken_reg) begin
            strapTaken_reg <= 1'b1;
            cells_reg <= cellCountStrapPin;
        end
    end

    // One-cycle pulse once the strap is held, so the defaults see the captured count
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            strapLoad_reg <= 1'b0;
        end else begin
            strapLoad_reg <= !strapTaken_reg;
        end
    end

    // Minimum system voltage field
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            floor_reg <= SYS_FLOOR_DEF_1S;
        end else if (loadDefaults && strapTaken_reg) begin
            floor_reg <= floorDefault;
        end else if (wrFloor) begin
            floor_reg <= hostAccess.data[5:0];
        end
    end

    // Charge voltage limit field
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            battery_regulation_voltage_reg <= BAT_BATTERY_REGULATION_VOLTAGE_DEF_1S;
        end else if (loadDefaults && strapTaken_reg) begin
            battery_regulation_voltage_reg <= vregDefault;
        end else if (wrVreg) begin
            battery_regulation_voltage_reg <= hostAccess.data[10:0];
        end
    end

    // Charge current limit field
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ilim_reg <= BAT_ILIM_DEF_LO;
        end else if ((loadDefaults || watchdogExpire) && strapTaken_reg) begin
            ilim_reg <= ilimDefault;
        end else if (wrIlim) begin
            ilim_reg <= hostAccess.data[8:0];
        end
    end

    // Input voltage threshold, follows adapter attach and detach
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            vth_reg <= IN_VTH_RESET;
            adapter_reg <= 1'b0;
        end else begin
            adapter_reg <= adapterPresent;
            if (adapter_reg && !adapterPresent) begin
                vth_reg <= IN_VTH_RESET;
            end else if (!adapter_reg && adapterPresent) begin
                vth_reg <= vthFromBus;
            end else if (wrVth) begin
                vth_reg <= hostAccess.data[7:0];
            end
        end
    end

    // Only a register reset restarts the timer, one cycle later
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            timerRestart <= 1'b0;
        end else begin
            timerRestart <= registerResetRequest;
        end
    end

    // Read path, reserved bits zero
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            readData <= 16'h0000;
            readValid <= 1'b0;
        end else begin
            readValid <= hostAccess.read;
            if (hostAccess.read) begin
                unique case (hostAccess.addr)
                    ADDR_SYS_FLOOR: readData <= {10'h000, floor_reg};
                    ADDR_BAT_BATTERY_REGULATION_VOLTAGE: readData <= {5'h00, battery_regulation_voltage_reg};
                    ADDR_BAT_ILIM: readData <= {7'h00, ilim_reg};
                    ADDR_IN_VTH: readData <= {8'h00, vth_reg};
                    default: readData <= 16'h0000;
                endcase
            end
        end
    end

    assign limits = '{floor_reg, battery_regulation_voltage_reg, ilim_reg, vth_reg};

    // Checks
    chk_floor_clamp_high: assert property (@(posedge sys_clk) disable iff (rst)
        hostAccess.write && hostAccess.addr == ADDR_SYS_FLOOR && hostAccess.data[5:0] > SYS_FLOOR_MAX
        && strapTaken_reg && !loadDefaults |=> $stable(floor_reg))
        else $error("floor took an out of range write");
    chk_battery_regulation_voltage_clamp_low: assert property (@(posedge sys_clk) disable iff (rst)
        hostAccess.write && hostAccess.addr == ADDR_BAT_BATTERY_REGULATION_VOLTAGE && hostAccess.data[10:0] < BAT_BATTERY_REGULATION_VOLTAGE_MIN
        && !loadDefaults && strapTaken_reg |=> $stable(battery_regulation_voltage_reg))
        else $error("charge voltage took a low write");
    chk_ilim_watchdog: assert property (@(posedge sys_clk) disable iff (rst)
        watchdogExpire && strapTaken_reg |=> ilim_reg == $past(ilimDefault))
        else $error("current not reloaded by watchdog");
    chk_battery_regulation_voltage_no_watchdog: assert property (@(posedge sys_clk) disable iff (rst)
        watchdogExpire && !loadDefaults && !wrVreg && strapTaken_reg |=> $stable(battery_regulation_voltage_reg))
        else $error("charge voltage changed by watchdog");
    chk_floor_reg_reset: assert property (@(posedge sys_clk) disable iff (rst)
        registerResetRequest && strapTaken_reg |=> floor_reg == $past(floorDefault))
        else $error("floor not reloaded");
    chk_vth_detach: assert property (@(posedge sys_clk) disable iff (rst)
        adapter_reg && !adapterPresent |=> vth_reg == IN_VTH_RESET)
        else $error("threshold not forced on detach");
    chk_vth_attach: assert property (@(posedge sys_clk) disable iff (rst)
        !adapter_reg && adapterPresent |=> vth_reg >= IN_VTH_MIN && vth_reg == $past(vthFromBus))
        else $error("threshold not loaded on attach");
    chk_vth_keeps: assert property (@(posedge sys_clk) disable iff (rst)
        (registerResetRequest || watchdogExpire) && adapter_reg == adapterPresent && !wrVth
        |=> $stable(vth_reg))
        else $error("threshold lost on reset source");
    chk_timer_restart: assert property (@(posedge sys_clk) disable iff (rst)
        registerResetRequest |=> timerRestart ##1 !timerRestart || $past(registerResetRequest))
        else $error("timer restart missing");
    chk_reserved_zero: assert property (@(posedge sys_clk) disable iff (rst)
        readValid |-> readData[15:11] == 5'h00)
        else $error("reserved bits not zero");
    chk_strap_held: assert property (@(posedge sys_clk) disable iff (rst)
        strapTaken_reg ##1 strapTaken_reg |-> $stable(cells_reg))
        else $error("cell count changed after capture");
    chk_power_on_load: assert property (@(posedge sys_clk) disable iff (rst)
        strapLoad_reg |=> floor_reg == $past(floorDefault) && battery_regulation_voltage_reg == $past(vregDefault)
        && ilim_reg == $past(ilimDefault))
        else $error("strap defaults not loaded");

endmodule : chglim_registers
